// ===== rtl/drive_element_status_formatter.sv
// Data transfer element descriptor framer with volume tag record.
// Assumes a same-clock register master and a byte sink that always accepts.
//
// Summary of operation
// - Address, sense, qualifier, tag at fixed bytes
// - Access flag refreshed on initialize or position
// - Tape-out policy: loaded tape unremovable until ejected
// - Tape-out policy: access when ejected or empty
// - Fitted policy: access when enabled drive installed
// - Bus identity present for CHANGER or OTHER
// - Unit number present for CHANGER or OTHER
// - Foreign bus flag only for OTHER
// - Logical unit number always zero
// - Configured bus ID always in byte 7
// - Tag: identifier, two zeros, sequence
// - Identifier left aligned, space padded
// - Pad option selects zero bytes
// - Undefined tag gives all-zero identifier
// - Sequence number is zero
// - No alternate tag records
// - Invert and source meaningful only when source valid
// - Tag cut to its first 4 identifier bytes when not requested: 16 bytes
`include "drive_desc_regs.svh"
`default_nettype none
module drive_element_status_formatter (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Descriptor byte stream
    output var drive_desc_pkg::desc_byte_t desc_out
);
    logic [2:0] ctrl_q;
    logic [15:0] cfg_q;
    logic [15:0] eaddr_q;
    logic [15:0] sense_q;
    logic [15:0] src_q;
    logic access_q;
    logic access_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    drive_desc_pkg::emit_state_t state_q;
    drive_desc_pkg::emit_state_t state_d;
    logic [6:0] idx_q;
    logic [6:0] idx_d;
    logic [6:0] len_q;
    logic [6:0] len_d;
    drive_desc_pkg::desc_byte_t out_q;
    drive_desc_pkg::desc_byte_t out_d;
    drive_desc_pkg::bus_flags_t flags;
    logic [7:0] tag_byte;
    logic [5:0] tag_used;
    logic [6:0] tag_off;
    logic access_now;
    logic wr_ctrl;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
        hit = (a == r);
    endfunction

    assign wr_ctrl = reg_wr && hit(reg_addr, `REG_CTRL);

    bus_flag_decode u_flags (
        .setting(drive_desc_pkg::bus_setting_t'(
            cfg_q[`CFG_BUS_LO +: 2])),
        .id_in(cfg_q[`CFG_ID_LO +: 4]),
        .flags(flags)
    );

    assign tag_off = idx_q - `TAG_BASE;
    tag_id_store #(
        .ID_LEN(32)
    ) u_tag (
        .clock(clock),
        .sys_rst(sys_rst),
        .clear(reg_wr && hit(reg_addr, `REG_TAGLEN)),
        .wr_en(reg_wr && hit(reg_addr, `REG_TAGWR)),
        .wr_byte(reg_wdata[7:0]),
        .rd_idx(tag_off[5:0]),
        .pad_zero(cfg_q[`CFG_PADZ]),
        .rd_byte(tag_byte),
        .used(tag_used)
    );

    // Access evaluation by the selected drive access policy
    always_comb begin
        if (cfg_q[`CFG_POLICY] == drive_desc_pkg::policy_drive_fitted) begin
            access_now = cfg_q[`CFG_FITTED] && cfg_q[`CFG_ENABLED];
        end else begin
            // A loaded, uneject tape cannot leave the drive
            access_now = !cfg_q[`CFG_HOLDS]
                || (cfg_q[`CFG_LOADED] ? cfg_q[`CFG_EJECTED]
                                        : 1'b1);
        end
    end

    // Access is latched only on initialize or position commands
    always_comb begin
        access_d = access_q;
        if (wr_ctrl && reg_wdata[`CTRL_UPDATE]) begin
            access_d = access_now;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ctrl_q <= 3'h0;
            cfg_q <= 16'h0000;
            eaddr_q <= 16'h0000;
            sense_q <= 16'h0000;
            src_q <= 16'h0000;
            access_q <= 1'b0;
        end else begin
            access_q <= access_d;
            if (wr_ctrl) begin
                ctrl_q <= {reg_wdata[`CTRL_PVOL], 2'h0};
            end
            if (reg_wr && hit(reg_addr, `REG_CFG)) begin
                cfg_q <= reg_wdata;
            end
            if (reg_wr && hit(reg_addr, `REG_EADDR)) begin
                eaddr_q <= reg_wdata;
            end
            if (reg_wr && hit(reg_addr, `REG_SENSE)) begin
                sense_q <= reg_wdata;
            end
            if (reg_wr && hit(reg_addr, `REG_SRC)) begin
                src_q <= reg_wdata;
            end
        end
    end

    // Read data valid the cycle after the strobe only
    always_comb begin
        rdata_d = 16'h0000;
        if (reg_rd) begin
            if (hit(reg_addr, `REG_CTRL)) begin
                rdata_d = {13'h0000, ctrl_q};
            end else if (hit(reg_addr, `REG_CFG)) begin
                rdata_d = cfg_q;
            end else if (hit(reg_addr, `REG_EADDR)) begin
                rdata_d = eaddr_q;
            end else if (hit(reg_addr, `REG_SENSE)) begin
                rdata_d = sense_q;
            end else if (hit(reg_addr, `REG_SRC)) begin
                rdata_d = src_q;
            end else if (hit(reg_addr, `REG_TAGLEN)) begin
                rdata_d = {10'h000, tag_used};
            end else if (hit(reg_addr, `REG_STATUS)) begin
                rdata_d = {13'h0000, state_q != drive_desc_pkg::ST_IDLE,
                           access_q, access_now};
            end
        end
    end

    // Byte of the descriptor at a given index
    function automatic logic [7:0] desc_at(input logic [6:0] i);
        logic [7:0] b;
        b = 8'h00;
        case (i)
            7'h00: b = eaddr_q[15:8];
            7'h01: b = eaddr_q[7:0];
            7'h02: b = {4'h0, access_q, cfg_q[`CFG_EXCEPT], 1'b0,
                        cfg_q[`CFG_FULL]};
            7'h04: b = sense_q[15:8];
            7'h05: b = sense_q[7:0];
            // LUN bits stay zero
            7'h06: b = {flags.foreign_bus, 1'b0, flags.bus_identity_present,
                        flags.unit_number_present, 4'h0};
            7'h07: b = {4'h0, flags.bus_id};
            // Invert is always zero; source zeroed when not valid
            7'h09: b = {cfg_q[`CFG_SVALID], 7'h00};
            7'h0A: b = cfg_q[`CFG_SVALID] ? src_q[15:8] : 8'h00;
            7'h0B: b = cfg_q[`CFG_SVALID] ? src_q[7:0] : 8'h00;
            default: begin
                // Tag record at 12..47: id, then zero pair and sequence
                if (i >= `TAG_BASE && tag_off < 7'(`TAG_ID_LEN)) begin
                    b = tag_byte;
                end else begin
                    b = 8'h00;
                end
            end
        endcase
        return b;
    endfunction

    // Start latches the length; one byte per cycle, no stall
    always_comb begin
        state_d = state_q;
        idx_d = idx_q;
        len_d = len_q;
        out_d = '0;
        case (state_q)
            drive_desc_pkg::ST_IDLE: begin
                if (wr_ctrl && reg_wdata[`CTRL_START]) begin
                    len_d = reg_wdata[`CTRL_PVOL] ? `DESC_LEN_TAG
                                                   : `DESC_LEN_NOTAG;
                    idx_d = 7'h00;
                    state_d = drive_desc_pkg::ST_SEND;
                end
            end
            drive_desc_pkg::ST_SEND: begin
                out_d.valid = 1'b1;
                out_d.data = desc_at(idx_q);
                out_d.last = (idx_q == len_q - 7'h01);
                idx_d = idx_q + 7'h01;
                if (out_d.last) begin
                    state_d = drive_desc_pkg::ST_DONE;
                end
            end
            drive_desc_pkg::ST_DONE: begin
                state_d = drive_desc_pkg::ST_IDLE;
            end
            default: begin
                state_d = drive_desc_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_q <= drive_desc_pkg::ST_IDLE;
            idx_q <= 7'h00;
            len_q <= 7'h00;
            out_q <= '0;
            rdata_q <= 16'h0000;
        end else begin
            state_q <= state_d;
            idx_q <= idx_d;
            len_q <= len_d;
            out_q <= out_d;
            rdata_q <= rdata_d;
        end
    end

    assign desc_out = out_q;
    assign reg_rdata = rdata_q;

    foreign_only_other_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        out_q.valid && idx_q == 7'h07 |->
            out_q.data[7] == (cfg_q[`CFG_BUS_LO +: 2] == 2'h2))
        else $error("foreign bus flag wrong");
    identity_flag_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        out_q.valid && idx_q == 7'h07 |->
            out_q.data[5] == (cfg_q[`CFG_BUS_LO +: 2] inside {2'h1, 2'h2}))
        else $error("identity flag wrong");
    unit_flag_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        out_q.valid && idx_q == 7'h07 |-> out_q.data[4] == out_q.data[5])
        else $error("unit flag wrong");
    lun_zero_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        out_q.valid && idx_q == 7'h07 |-> out_q.data[2:0] == 3'h0)
        else $error("lun not zero");
    // Byte k is registered k+1 edges after the start edge and sampled
    // one edge later, so the final byte shows at start plus length plus 1
    short_frame_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        wr_ctrl && reg_wdata[`CTRL_START] && !reg_wdata[`CTRL_PVOL]
            && state_q == drive_desc_pkg::ST_IDLE
        |-> ##17 out_q.last)
        else $error("short descriptor length wrong");
    long_frame_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        wr_ctrl && reg_wdata[`CTRL_START] && reg_wdata[`CTRL_PVOL]
            && state_q == drive_desc_pkg::ST_IDLE
        |-> ##53 out_q.last)
        else $error("long descriptor length wrong");
    access_update_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        wr_ctrl && reg_wdata[`CTRL_UPDATE]
        |=> access_q == $past(access_now))
        else $error("access not refreshed");
    access_hold_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        !(wr_ctrl && reg_wdata[`CTRL_UPDATE]) |=> $stable(access_q))
        else $error("access changed without command");
    reserved_zero_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        out_q.valid && (idx_q == 7'h04 || idx_q == 7'h09 || idx_q > 7'h30)
        |-> out_q.data == 8'h00)
        else $error("reserved byte not zero");
    source_gate_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        out_q.valid && !cfg_q[`CFG_SVALID] && idx_q inside {7'h0B, 7'h0C}
        |-> out_q.data == 8'h00)
        else $error("source shown while invalid");
endmodule
`default_nettype wire

// ===== rtl/drive_desc_regs.svh
// Descriptor layout constants and register offsets.
// Assumes inclusion by bare name from rtl/ files.
`ifndef DRIVE_DESC_REGS_SVH
`define DRIVE_DESC_REGS_SVH

`define DESC_LEN_TAG 7'h34
`define DESC_LEN_NOTAG 7'h10
`define TAG_BASE 7'h0C
`define TAG_ID_LEN 6'h20
`define PAD_SPACE 8'h20
`define PAD_ZERO 8'h00

`define REG_CTRL 4'h0
`define REG_CFG 4'h1
`define REG_EADDR 4'h2
`define REG_SENSE 4'h3
`define REG_SRC 4'h4
`define REG_TAGLEN 4'h5
`define REG_STATUS 4'h6
`define REG_TAGWR 4'h7

`define CTRL_START 0
`define CTRL_UPDATE 1
`define CTRL_PVOL 2
`define CFG_POLICY 0
`define CFG_BUS_LO 1
`define CFG_PADZ 3
`define CFG_FITTED 4
`define CFG_ENABLED 5
`define CFG_LOADED 6
`define CFG_EJECTED 7
`define CFG_HOLDS 8
`define CFG_ID_LO 9
`define CFG_SVALID 13
`define CFG_FULL 14
`define CFG_EXCEPT 15

`endif

// ===== rtl/drive_desc_pkg.sv
// Types shared by the descriptor formatter files.
// Assumes the _regs header carries the numbers.
`default_nettype none
package drive_desc_pkg;
    typedef enum logic [1:0] {
        BUS_INVALID = 2'h0,
        BUS_CHANGER = 2'h1,
        BUS_OTHER = 2'h2
    } bus_setting_t;
    typedef enum logic {
        POLICY_TAPE_OUT = 1'b0,
        policy_drive_fitted = 1'b1
    } access_policy_t;
    typedef struct packed {
        logic foreign_bus;
        logic bus_identity_present;
        logic unit_number_present;
        logic [3:0] bus_id;
    } bus_flags_t;
    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic last;
    } desc_byte_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_SEND = 2'h1,
        ST_DONE = 2'h3
    } emit_state_t;
endpackage
`default_nettype wire

// ===== rtl/bus_flag_decode.sv
// Turns the per-drive bus setting into the byte 6 flags.
// Assumes setting and id are static register values.
`default_nettype none
module bus_flag_decode (
    // Configuration
    input wire drive_desc_pkg::bus_setting_t setting,
    input wire logic [3:0] id_in,
    // Flags
    output var drive_desc_pkg::bus_flags_t flags
);
    always_comb begin
        flags.foreign_bus = (setting == drive_desc_pkg::BUS_OTHER);
        flags.bus_identity_present = (setting == drive_desc_pkg::BUS_CHANGER)
            || (setting == drive_desc_pkg::BUS_OTHER);
        flags.unit_number_present = flags.bus_identity_present;
        flags.bus_id = id_in;
    end
endmodule
`default_nettype wire

// ===== rtl/tag_id_store.sv
// Holds the volume identifier bytes and serves one padded byte by index.
// Assumes writes append bytes in order from position 0.
`include "drive_desc_regs.svh"
`default_nettype none
module tag_id_store #(
    parameter int ID_LEN = 32
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Fill
    input wire logic clear,
    input wire logic wr_en,
    input wire logic [7:0] wr_byte,
    // Lookup
    input wire logic [5:0] rd_idx,
    input wire logic pad_zero,
    output logic [7:0] rd_byte,
    output logic [5:0] used
);
    logic [7:0] mem_q [ID_LEN];
    logic [5:0] used_q;
    logic [5:0] used_d;

    always_comb begin
        used_d = used_q;
        if (clear) begin
            used_d = 6'h00;
        end else if (wr_en && used_q < 6'(ID_LEN)) begin
            used_d = used_q + 6'h01;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            used_q <= 6'h00;
        end else begin
            used_q <= used_d;
        end
        if (wr_en && !clear && used_q < 6'(ID_LEN)) begin
            mem_q[used_q[4:0]] <= wr_byte;
        end
    end

    // Undefined tag (length 0) is all zero; else pad after used bytes
    always_comb begin
        if (used_q == 6'h00) begin
            rd_byte = 8'h00;
        end else if (rd_idx < used_q) begin
            rd_byte = mem_q[rd_idx[4:0]];
        end else if (pad_zero) begin
            rd_byte = `PAD_ZERO;
        end else begin
            rd_byte = `PAD_SPACE;
        end
    end
    assign used = used_q;
endmodule
`default_nettype wire

// ===== tb/desc_sink.sv
// Initiator-side model that collects one descriptor frame at a time.
// Assumes one byte per valid cycle; it never stalls the framer.
`default_nettype none
module desc_sink (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Descriptor stream
    input wire drive_desc_pkg::desc_byte_t desc_in,
    // Collected frame
    output logic [7:0] rx [0:51],
    output logic [6:0] rx_len,
    output logic [7:0] rx_frames
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [6:0] idx_q;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            idx_q <= 7'h00;
            rx_len <= 7'h00;
            rx_frames <= 8'h00;
        end else if (desc_in.valid) begin
            // Overlong frames are dropped past byte 51, not wrapped
            if (idx_q < 7'h34) begin
                rx[idx_q[5:0]] <= desc_in.data;
            end
            if (desc_in.last) begin
                idx_q <= 7'h00;
                rx_len <= idx_q + 7'h01;
                rx_frames <= rx_frames + 8'h01;
            end else begin
                idx_q <= idx_q + 7'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb/drive_element_status_formatter_test.sv
// Self-checking bench for the drive element descriptor framer.
// Assumes the register map of drive_desc_regs.svh and desc_sink.
`include "drive_desc_regs.svh"
`default_nettype none
module drive_element_status_formatter_test;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [15:0] elem_addr = 16'h01A5;
    localparam logic [15:0] sense_word = 16'h3A02;
    localparam logic [15:0] src_addr = 16'h0123;
    localparam logic [15:0] acc_cfg [0:4] = '{16'h0031, 16'h0011,
        16'h0140, 16'h01C0, 16'h0100};
    logic clock;
    logic sys_rst;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_rdata;
    drive_desc_pkg::desc_byte_t desc_out;
    logic [7:0] rx [0:51];
    logic [6:0] rx_len;
    logic [7:0] rx_frames;
    logic [7:0] exp_b [0:51];
    logic [7:0] tag_txt [0:5];
    int n_mismatch;
    int check_count;

    drive_element_status_formatter drive_element_status_formatter_i (
        .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .desc_out(desc_out));
    desc_sink desc_sink_i (
        .clock(clock), .sys_rst(sys_rst), .desc_in(desc_out),
        .rx(rx), .rx_len(rx_len), .rx_frames(rx_frames));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] expv);
        check_count++;
        if (seen !== expv) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, expv, seen);
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    function automatic logic access_of(input logic [15:0] c);
        if (c[`CFG_POLICY]) begin
            return c[`CFG_FITTED] & c[`CFG_ENABLED];
        end
        return !(c[`CFG_HOLDS] & c[`CFG_LOADED] & !c[`CFG_EJECTED]);
    endfunction

    task automatic build(input logic [15:0] c, input logic [5:0] nid);
        logic [1:0] bus;
        bus = c[2:1];
        foreach (exp_b[i]) exp_b[i] = 8'h00;
        exp_b[0] = elem_addr[15:8];
        exp_b[1] = elem_addr[7:0];
        exp_b[2] = {4'h0, access_of(c), c[`CFG_EXCEPT], 1'b0, c[`CFG_FULL]};
        exp_b[4] = sense_word[15:8];
        exp_b[5] = sense_word[7:0];
        exp_b[6] = {bus == 2'h2, 1'b0, bus != 2'h0, bus != 2'h0, 4'h0};
        exp_b[7] = {4'h0, c[12:9]};
        exp_b[9] = {c[`CFG_SVALID], 7'h00};
        if (c[`CFG_SVALID]) begin
            exp_b[10] = src_addr[15:8];
            exp_b[11] = src_addr[7:0];
        end
        // Undefined tag leaves the identifier at zero
        for (int i = 0; i < 32 && nid != 6'h00; i++) begin
            exp_b[12 + i] = (i < nid) ? tag_txt[i] :
                (c[`CFG_PADZ] ? 8'h00 : 8'h20);
        end
    endtask

    task automatic load_tag(input logic [5:0] n);
        logic [15:0] d;
        wr(`REG_TAGLEN, 16'h0000);
        for (int i = 0; i < n; i++) wr(`REG_TAGWR, {8'h00, tag_txt[i]});
        rd(`REG_TAGLEN, d);
        check("tag length", d, {10'h000, n});
    endtask

    task automatic run_frame(input logic [15:0] c, input logic pvol,
                             input logic [5:0] nid);
        logic [7:0] f0;
        int n;
        wr(`REG_CFG, c);
        wr(`REG_CTRL, 16'h0002);
        build(c, nid);
        f0 = rx_frames;
        wr(`REG_CTRL, {13'h0000, pvol, 2'h1});
        n = 0;
        while (rx_frames == f0 && n < 200) begin
            @(posedge clock);
            #1;
            n++;
        end
        if (n == 200) begin
            n_mismatch++;
            end_of_test();
        end
        check("length", {9'h000, rx_len},
            pvol ? 16'h0034 : 16'h0010);
        for (int i = 0; i < rx_len; i++) begin
            check("byte", {8'h00, rx[i]},
                {8'h00, exp_b[i]});
        end
    endtask

    task automatic s_reset;
        logic [15:0] d;
        logic [3:0] idx [0:3];
        idx = '{`REG_CFG, `REG_CTRL, `REG_TAGLEN, 4'hF};
        foreach (idx[i]) begin
            rd(idx[i], d);
            check("reset read", d, 16'h0000);
        end
    endtask

    task automatic s_access;
        logic [15:0] d;
        rd(`REG_STATUS, d);
        check("access before update", {14'h0000, d[1:0]}, 16'h0001);
        foreach (acc_cfg[i]) begin
            wr(`REG_CFG, acc_cfg[i]);
            wr(`REG_CTRL, 16'h0002);
            rd(`REG_STATUS, d);
            check("access", {15'h0000, d[1]},
                {15'h0000, access_of(acc_cfg[i])});
        end
        // Without an update command the reported bit must not follow
        wr(`REG_CFG, 16'h0140);
        rd(`REG_STATUS, d);
        check("access held", {14'h0000, d[1:0]}, 16'h0002);
    endtask

    initial begin
        sys_rst = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        n_mismatch = 0;
        check_count = 0;
        // Identifier without wildcards or embedded blanks
        tag_txt = '{8'h54, 8'h41, 8'h50, 8'h45, 8'h30, 8'h31};
        repeat (16) @(posedge clock);
        sys_rst <= 1'b0;
        s_reset();
        s_access();
        wr(`REG_EADDR, elem_addr);
        wr(`REG_SENSE, sense_word);
        wr(`REG_SRC, src_addr);
        load_tag(6'h06);
        run_frame(16'hEA33, 1'b1, 6'h06);
        run_frame(16'h1F44, 1'b0, 6'h06);
        run_frame(16'h0608, 1'b1, 6'h06);
        load_tag(6'h00);
        run_frame(16'h0600, 1'b1, 6'h00);
        end_of_test();
    end
endmodule
`default_nettype wire
